//--- pscp_pkg.sv
// shared constants for the passive serial configuration port
package pscp_pkg;
  // ==========================================
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int INIT_OSC_HZ = 10_000_000;
  localparam int INIT_DIV = CLK_HZ / INIT_OSC_HZ;
  localparam int INIT_DIV_W = 4;
  localparam int POR_DELAY_MS = 2;
  localparam int POR_CYCLES = POR_DELAY_MS * (CLK_HZ / 1000);
  localparam int RESTART_TIMEOUT_US = 40;
  localparam int RESTART_CYCLES = RESTART_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int INIT_CYCLES = 16;
  localparam int CNT_W = 24;
  // ==========================================
  // bitstream layout
  localparam int FRAME_BITS = 8;
  localparam int STREAM_BITS = 64;
  localparam logic [7:0] FRAME_SYNC = 8'ha5;
  localparam int BIT_CNT_W = 32;
  // ==========================================
  // states
  typedef enum logic [2:0] {
    PSCP_POR = 3'b000,
    PSCP_CLEAR = 3'b001,
    PSCP_LOAD = 3'b011,
    PSCP_INIT = 3'b010,
    PSCP_USER = 3'b110,
    PSCP_ERROR = 3'b111
  } pscp_state_e;
endpackage

//--- pscp_sync.sv
// two-flop synchroniser with edge detection after the second stage
`timescale 1ns/100ps
module pscp_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q,
  output logic rise,
  output logic fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign q = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
endmodule

//--- pscp_div.sv
// divider making a one-cycle enable at the init oscillator rate
`timescale 1ns/100ps
module pscp_div #(
  parameter int DIV = 4,
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic tick
);
  logic [W-1:0] cnt_q;

  // counter held at zero when stopped: the oscillator is off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (!run) begin
      cnt_q <= '0;
    end else if (cnt_q == W'(DIV - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign tick = run && (cnt_q == W'(DIV - 1));
endmodule

//--- pscp_top.sv
// passive serial configuration port of the target device
`timescale 1ns/100ps
// What this block does
// - capture serial data on every rising edge of the host configuration clock while loading with chain-enable in low
// - a rising edge on the request input, incl. power-up, starts configuration
// - hold open-drain done low while configuring, selecting the memory
// - release the status line on leaving power-on reset once the request is high
// - no data transfer until every device has released status
// - run initialization from a 10 MHz oscillator, stop it afterwards
// - release done after configuration, enter user mode after initialization
// - on a configuration error pull the status line low
// - with auto-restart on, restart by itself after an error
// - release done on finishing so the memory is deselected
// - with auto-restart, reset then pulse status; memory restarts on release
// - nobody holds done low; done low afterwards means failure
// - assert chain-enable out when own configuration completes
// - targets with tied done lines initialize and enter user mode together
// - a status error anywhere halts configuration of the whole chain
// - after error: release after time-out if auto-restart, else wait for request
module pscp_top
  import pscp_pkg::*;
#(
  parameter int POR_CNT = POR_CYCLES,
  parameter int RESTART_CNT = RESTART_CYCLES,
  parameter int STREAM_LEN = STREAM_BITS
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CFG_REQUEST,
  input wire logic CFG_SERIAL_CLOCK,
  input wire logic SERIAL_CFG_DATA_IN,
  input wire logic CHAIN_ENABLE_IN_N,
  input wire logic AUTO_RESTART_EN,
  input wire logic STATUS_IN,
  output logic STATUS_OE,
  output logic STATUS_OUT,
  input wire logic DONE_IN,
  output logic DONE_OE,
  output logic DONE_OUT,
  output logic CHAIN_ENABLE_OUT_N,
  output logic INIT_OSC_ON,
  output logic USER_MODE,
  output logic CFG_ERROR,
  output logic [FRAME_BITS-1:0] CFG_WORD,
  output logic CFG_WORD_VALID
);
  import pscp_pkg::*;

  // ==========================================
  // input synchronisers
  logic req_s;
  logic req_fall;
  logic cfg_serial_clock_rise;
  logic data_s;
  logic ce_n_s;
  logic status_s;
  logic done_s;
  logic auto_s;

  pscp_sync #(.INIT(1'b0)) u_req (
    .clk(CLK), .rst(SYS_RST), .d(CFG_REQUEST),
    .q(req_s), .rise(), .fall(req_fall)
  );
  pscp_sync #(.INIT(1'b0)) u_cfg_serial_clock (
    .clk(CLK), .rst(SYS_RST), .d(CFG_SERIAL_CLOCK),
    .q(), .rise(cfg_serial_clock_rise), .fall()
  );
  // data path gets the same delay as the clock so the bit is aligned
  pscp_sync #(.INIT(1'b0)) u_data (
    .clk(CLK), .rst(SYS_RST), .d(SERIAL_CFG_DATA_IN),
    .q(data_s), .rise(), .fall()
  );
  pscp_sync #(.INIT(1'b1)) u_ce (
    .clk(CLK), .rst(SYS_RST), .d(CHAIN_ENABLE_IN_N),
    .q(ce_n_s), .rise(), .fall()
  );
  pscp_sync #(.INIT(1'b0)) u_status (
    .clk(CLK), .rst(SYS_RST), .d(STATUS_IN),
    .q(status_s), .rise(), .fall()
  );
  pscp_sync #(.INIT(1'b0)) u_done (
    .clk(CLK), .rst(SYS_RST), .d(DONE_IN),
    .q(done_s), .rise(), .fall()
  );
  // option strap is a pin as well, so it is synchronised like the rest
  pscp_sync #(.INIT(1'b0)) u_auto (
    .clk(CLK), .rst(SYS_RST), .d(AUTO_RESTART_EN),
    .q(auto_s), .rise(), .fall()
  );

  // ==========================================
  // state and counters
  pscp_state_e state_q;
  logic [CNT_W-1:0] tmr_q;
  logic [BIT_CNT_W-1:0] bit_cnt_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [$clog2(FRAME_BITS)-1:0] frame_pos_q;
  logic sync_seen_q;
  logic status_drive_q;
  logic done_drive_q;
  logic ceo_n_q;
  logic err_q;
  logic init_tick;
  logic osc_run;
  logic frame_err;
  logic load_done;
  logic accept_bit;

  assign osc_run = (state_q == PSCP_INIT);
  assign accept_bit = (state_q == PSCP_LOAD) && cfg_serial_clock_rise && !ce_n_s && status_s;
  assign load_done = (bit_cnt_q == BIT_CNT_W'(STREAM_LEN - 1)) && accept_bit;
  // first full frame must carry the sync pattern; anything else is a bad stream
  assign frame_err = accept_bit && !sync_seen_q
                     && (frame_pos_q == 3'(FRAME_BITS - 1))
                     && ({shift_q[FRAME_BITS-2:0], data_s} != FRAME_SYNC);

  pscp_div #(.DIV(INIT_DIV), .W(INIT_DIV_W)) u_osc (
    .clk(CLK), .rst(SYS_RST), .run(osc_run), .tick(init_tick)
  );

  // ==========================================
  // sequencer
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= PSCP_POR;
      tmr_q <= '0;
    end else begin
      case (state_q)
        PSCP_POR: begin
          // status held low until the power-on delay has run out
          if (tmr_q == CNT_W'(POR_CNT - 1)) begin
            state_q <= PSCP_CLEAR;
            tmr_q <= '0;
          end else begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
        PSCP_CLEAR: begin
          // a new cycle needs the request high; power-up counts as its rising edge
          if (req_s && status_s) begin
            state_q <= PSCP_LOAD;
          end
        end
        PSCP_LOAD: begin
          if (req_fall) begin
            state_q <= PSCP_CLEAR;
          end else if (frame_err) begin
            state_q <= PSCP_ERROR;
            tmr_q <= '0;
          end else if (!status_s) begin
            state_q <= PSCP_ERROR;
            tmr_q <= '0;
          end else if (load_done) begin
            state_q <= PSCP_INIT;
            tmr_q <= '0;
          end
        end
        PSCP_INIT: begin
          // tied done lines: start init counting only once the shared net is high
          if (req_fall) begin
            state_q <= PSCP_CLEAR;
          end else if (!status_s) begin
            state_q <= PSCP_ERROR;
            tmr_q <= '0;
          end else if (done_s && init_tick) begin
            if (tmr_q == CNT_W'(INIT_CYCLES - 1)) begin
              state_q <= PSCP_USER;
              tmr_q <= '0;
            end else begin
              tmr_q <= tmr_q + 1'b1;
            end
          end
        end
        PSCP_USER: begin
          if (req_fall) begin
            state_q <= PSCP_CLEAR;
          end
        end
        PSCP_ERROR: begin
          if (auto_s) begin
            if (tmr_q == CNT_W'(RESTART_CNT - 1)) begin
              state_q <= PSCP_CLEAR;
              tmr_q <= '0;
            end else begin
              tmr_q <= tmr_q + 1'b1;
            end
          end else if (req_fall) begin
            state_q <= PSCP_CLEAR;
            tmr_q <= '0;
          end
        end
        default: begin
          state_q <= PSCP_POR;
          tmr_q <= '0;
        end
      endcase
    end
  end

  // ==========================================
  // bit capture
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      shift_q <= '0;
      bit_cnt_q <= '0;
      frame_pos_q <= '0;
      sync_seen_q <= 1'b0;
    end else if (state_q != PSCP_LOAD) begin
      bit_cnt_q <= '0;
      frame_pos_q <= '0;
      sync_seen_q <= 1'b0;
    end else if (accept_bit) begin
      shift_q <= {shift_q[FRAME_BITS-2:0], data_s};
      bit_cnt_q <= bit_cnt_q + 1'b1;
      frame_pos_q <= frame_pos_q + 1'b1;
      if (frame_pos_q == 3'(FRAME_BITS - 1)) begin
        sync_seen_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CFG_WORD <= '0;
      CFG_WORD_VALID <= 1'b0;
    end else begin
      CFG_WORD_VALID <= 1'b0;
      if (accept_bit && frame_pos_q == 3'(FRAME_BITS - 1)) begin
        CFG_WORD <= {shift_q[FRAME_BITS-2:0], data_s};
        CFG_WORD_VALID <= 1'b1;
      end
    end
  end

  // ==========================================
  // open-drain handshakes and chain enable
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      status_drive_q <= 1'b1;
      done_drive_q <= 1'b1;
      ceo_n_q <= 1'b1;
      err_q <= 1'b0;
    end else begin
      // request low: keep status held so the host cannot stream before bits are taken
      status_drive_q <= (state_q == PSCP_POR) || (state_q == PSCP_ERROR)
                        || ((state_q == PSCP_CLEAR) && !req_s);
      // done held low from reset until our own stream is in
      done_drive_q <= (state_q == PSCP_POR) || (state_q == PSCP_CLEAR)
                      || (state_q == PSCP_LOAD) || (state_q == PSCP_ERROR);
      ceo_n_q <= !((state_q == PSCP_INIT) || (state_q == PSCP_USER));
      if (state_q == PSCP_ERROR) begin
        err_q <= 1'b1;
      end else if (state_q == PSCP_LOAD) begin
        err_q <= 1'b0;
      end
    end
  end

  assign STATUS_OE = status_drive_q;
  assign STATUS_OUT = 1'b0;
  assign DONE_OE = done_drive_q;
  assign DONE_OUT = 1'b0;
  assign CHAIN_ENABLE_OUT_N = ceo_n_q;
  assign INIT_OSC_ON = osc_run;
  assign USER_MODE = (state_q == PSCP_USER);
  assign CFG_ERROR = err_q;
endmodule

//--- pscp_chk.sv
// assertion checker for the configuration port
`timescale 1ns/100ps
module pscp_chk #(
  parameter int POR_CNT = 20,
  parameter int RESTART_CNT = 10
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CFG_REQUEST,
  input wire logic AUTO_RESTART_EN,
  input wire logic DONE_IN,
  input wire logic STATUS_OE,
  input wire logic DONE_OE,
  input wire logic CHAIN_ENABLE_OUT_N,
  input wire logic INIT_OSC_ON,
  input wire logic USER_MODE,
  input wire logic CFG_ERROR,
  input wire logic CFG_WORD_VALID
);
  int cyc_q, err_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // ==========
  // cycles since reset, cycles spent pulling status in error
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cyc_q <= 0;
      err_q <= 0;
    end else begin
      cyc_q <= (cyc_q < POR_CNT) ? cyc_q + 1 : cyc_q;
      // a low request legally extends the hold, so only count while it is high
      err_q <= (CFG_ERROR && STATUS_OE && CFG_REQUEST) ? err_q + 1 : 0;
    end
  end
  // ==========
  // properties
  por_hold_a: assert property (cyc_q < POR_CNT |-> STATUS_OE)
    else $error("status freed in power-on hold");
  auto_rel_a: assert property (AUTO_RESTART_EN |-> err_q <= RESTART_CNT + 3)
    else $error("error hold past time-out");
  err_pull_a: assert property ($rose(CFG_ERROR) |-> ##[0:1] STATUS_OE)
    else $error("error without status pull");
  done_rel_a: assert property ($fell(DONE_OE) |-> INIT_OSC_ON)
    else $error("done freed outside init");
  chain_out_a: assert property ($fell(CHAIN_ENABLE_OUT_N) |-> INIT_OSC_ON && !DONE_OE)
    else $error("chain enable out early");
  user_osc_a: assert property (USER_MODE |-> !INIT_OSC_ON && !DONE_OE)
    else $error("oscillator or done wrong in user mode");
  user_init_a: assert property ($rose(USER_MODE) |-> $past(INIT_OSC_ON) && $past(DONE_IN))
    else $error("user mode without init");
  word_pulse_a: assert property (CFG_WORD_VALID |=> !CFG_WORD_VALID)
    else $error("word strobe too long");
  req_hold_a: assert property (!CFG_REQUEST [*6] |-> STATUS_OE)
    else $error("status freed while request low");
  cover property ($rose(USER_MODE));
  cover property ($rose(CFG_ERROR) && AUTO_RESTART_EN);
  cover property ($rose(CFG_ERROR) && !AUTO_RESTART_EN);
endmodule
bind pscp_top pscp_chk #(.POR_CNT(POR_CNT), .RESTART_CNT(RESTART_CNT)) chk_u (
  .CLK, .SYS_RST, .CFG_REQUEST, .AUTO_RESTART_EN, .DONE_IN, .STATUS_OE, .DONE_OE,
  .CHAIN_ENABLE_OUT_N, .INIT_OSC_ON, .USER_MODE, .CFG_ERROR, .CFG_WORD_VALID);

//--- pscp_mem.sv
// serial configuration memory model
`timescale 1ns/100ps
module pscp_mem #(
  parameter int BITS = 64,
  parameter int POR_NS = 1000
) (
  input wire logic [BITS-1:0] image,
  input wire logic status_in,
  input wire logic done_in,
  output logic pull,
  output logic sclk,
  output logic sdata
);
  int i;
  // ==========
  // stream while selected; clock parked low outside frames
  initial begin
    pull = 1'b1;
    sclk = 1'b0;
    sdata = 1'b0;
    #(POR_NS);
    pull = 1'b0;
    forever begin
      wait (status_in && !done_in);
      // keep link edges clear of the target's clock edges
      #5;
      // one unbroken stream: a cascaded next part takes over within a bit time
      for (i = BITS - 1; i >= 0 && status_in; i--) begin
        sdata = image[i];
        #100 sclk = 1'b1;
        #100 sclk = 1'b0;
      end
      sdata = ~sdata;
      if (i < 0) begin
        #2000;
        // done still low after all data: force a chain reset
        if (!done_in) begin
          pull = 1'b1;
          #3000 pull = 1'b0;
        end
      end
    end
  end
endmodule

//--- pscp_tb_top.sv
// bench: power-up, chain enable, request and auto restart
`timescale 1ns/100ps
module pscp_tb_top;
  import pscp_pkg::*;
  localparam logic [63:0] GOOD = {FRAME_SYNC, 56'h3c0f817ec35596};
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, ce_n = 1'b1, auto = 1'b0, tb_dn = 1'b0;
  logic [63:0] img = GOOD;
  logic st_oe, dn_oe, st_out, dn_out, ceo_n, osc, user, err, wvalid, mem_pull, sclk, sdata;
  logic [7:0] word, words[$];
  int err_total, check_count, osc_n;
  // open-drain nets: an enabled driver sets the level, otherwise the pull-up wins
  wire logic status = (st_oe ? st_out : 1'b1) & !mem_pull;
  wire logic done = (dn_oe ? dn_out : 1'b1) & !tb_dn;
  pscp_top #(.POR_CNT(20), .RESTART_CNT(10)) dut_u (
    .CLK(clk), .SYS_RST(rst), .CFG_REQUEST(req), .CFG_SERIAL_CLOCK(sclk),
    .SERIAL_CFG_DATA_IN(sdata), .CHAIN_ENABLE_IN_N(ce_n), .AUTO_RESTART_EN(auto),
    .STATUS_IN(status), .STATUS_OE(st_oe), .STATUS_OUT(st_out), .DONE_IN(done),
    .DONE_OE(dn_oe), .DONE_OUT(dn_out), .CHAIN_ENABLE_OUT_N(ceo_n), .INIT_OSC_ON(osc),
    .USER_MODE(user), .CFG_ERROR(err), .CFG_WORD(word), .CFG_WORD_VALID(wvalid));
  pscp_mem #(.BITS(64), .POR_NS(1000)) mem_u (.image(img), .status_in(status),
    .done_in(done), .pull(mem_pull), .sclk(sclk), .sdata(sdata));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (wvalid === 1'b1) words.push_back(word);
    if (osc === 1'b1) osc_n++;
  end
  // ==========
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_on(ref logic s, input logic v);
    for (int n = 0; n < 4000 && s !== v; n++) cyc(1);
    chk(s, v);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_por;
    req = 1'b1;
    cyc(10);
    chk(st_oe, 1);
    chk(ceo_n, 1);
    cyc(14);
    chk(st_oe, 0);
    chk(status, 0);
  endtask
  task automatic t_chain_off;
    wait_on(err, 1);
    chk(words.size(), 0);
    chk(st_oe, 1);
    chk(st_out, 0);
    cyc(200);
    chk(st_oe, 1);
  endtask
  task automatic t_request;
    ce_n = 1'b0;
    words.delete();
    req = 1'b0;
    cyc(10);
    req = 1'b1;
    wait_on(st_oe, 0);
    chk(dn_oe, 1);
    chk(dn_out, 0);
    // a peer target still loading keeps the shared done low
    tb_dn = 1'b1;
    wait_on(ceo_n, 0);
    cyc(50);
    chk(user, 0);
    tb_dn = 1'b0;
    osc_n = 0;
    wait_on(user, 1);
    chk(osc_n >= 60, 1);
    chk(osc, 0);
    chk(dn_oe, 0);
    chk(words.size(), 8);
    for (int k = 0; k < 8; k++) chk(words[k], img[63-8*k -: 8]);
  endtask
  task automatic t_auto;
    auto = 1'b1;
    img[63:56] = 8'h5a;
    req = 1'b0;
    cyc(10);
    chk(st_oe, 1);
    req = 1'b1;
    wait_on(err, 1);
    img = GOOD;
    cyc(2);
    chk(st_oe, 1);
    wait_on(st_oe, 0);
    wait_on(user, 1);
    chk(err, 0);
  endtask
  initial begin
    cyc(6);
    rst = 1'b0;
    t_por;
    t_chain_off;
    t_request;
    t_auto;
    stop_test;
  end
  initial begin
    #500_000;
    err_total++;
    stop_test;
  end
endmodule
